//--- verilog/guard_cmd_pkg.sv
// Package: command codes, addresses, timing and carriers for the guard command host
package guard_cmd_pkg;
    localparam int          ADDR_W        = 27;
    localparam int          SECTOR_LSB    = 16;
    localparam int          CMD_ADDR_W    = 11;
    localparam logic [7:0]  UNLOCK1_DATA  = 8'haa;
    localparam logic [7:0]  UNLOCK2_DATA  = 8'h55;
    localparam logic [10:0] UNLOCK1_ADDR  = 11'haaa;
    localparam logic [10:0] UNLOCK2_ADDR  = 11'h555;
    localparam logic [7:0]  ENTER_PERSIST = 8'hc0;
    localparam logic [7:0]  ENTER_FREEZE  = 8'h50;
    localparam logic [7:0]  ENTER_VOLAT   = 8'he0;
    localparam logic [7:0]  ENTER_ECC     = 8'h75;
    localparam logic [7:0]  PROG_DATA     = 8'ha0;
    localparam logic [7:0]  ERASE_DATA    = 8'h80;
    localparam logic [7:0]  ERASE_CONFIRM = 8'h30;
    localparam logic [7:0]  EXIT1_DATA    = 8'h90;
    localparam logic [7:0]  EXIT2_DATA    = 8'h00;
    localparam logic [7:0]  RESET_DATA    = 8'hf0;
    localparam logic [7:0]  SET_DATA      = 8'h00;
    localparam logic [7:0]  CLEAR_DATA    = 8'h01;
    localparam logic [7:0]  PROTECTED_VAL = 8'h00;
    localparam int          GUARD_BIT     = 0;
    localparam int          TIMEOUT_BIT   = 5;
    // Bus cycle phase times in ns
    localparam int          T_SETUP_NS    = 30;
    localparam int          T_PULSE_NS    = 35;
    localparam int          T_READ_NS     = 100;
    localparam int          CLK_NS        = 5;
    localparam int          SETUP_CYC     = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int          PULSE_CYC     = (T_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int          READ_CYC      = (T_READ_NS + CLK_NS - 1) / CLK_NS;
    localparam int          CNT_W         = 6;

    typedef enum logic [3:0] {
        OP_ENTER_PERSIST,
        OP_ENTER_FREEZE,
        OP_ENTER_VOLAT,
        OP_ENTER_ECC,
        OP_PERSIST_PROG,
        OP_PERSIST_ERASE,
        OP_VOLAT_SET,
        OP_VOLAT_CLEAR,
        OP_FREEZE_CLEAR,
        OP_READ,
        OP_EXIT,
        OP_RESET
    } op_t;

    typedef enum logic [2:0] {
        OV_ARRAY,
        OV_PERSIST,
        OV_FREEZE,
        OV_VOLAT,
        OV_ECC
    } overlay_space_t;

    typedef struct packed {
        op_t               op;
        logic [ADDR_W-1:0] addr;
    } cmd_t;

    typedef struct packed {
        logic              we;
        logic [ADDR_W-1:0] addr;
        logic [7:0]        data;
    } bus_cycle_t;
endpackage

//--- verilog/guard_cmd_host.sv
// Host controller issuing sector guard and overlay command sequences to a parallel flash
`timescale 1ns/1ps
module guard_cmd_host
(
    // Clock and reset
    input  wire logic                        CLK,
    input  wire logic                        NRST,
    // User command port
    input  wire logic                        CMD_VALID,
    input  wire guard_cmd_pkg::cmd_t         CMD,
    output logic                             CMD_READY,
    output logic                             RSP_VALID,
    output logic [7:0]                       RSP_DATA,
    output logic                             RSP_GUARDED,
    output guard_cmd_pkg::overlay_space_t    OVERLAY,
    output logic                             TIMEOUT_SEEN,
    // Flash pins
    output logic [guard_cmd_pkg::ADDR_W-1:0] FL_ADDR,
    output logic                             FL_CE_N,
    output logic                             FL_WE_N,
    output logic                             FL_OE_N,
    input  wire logic [7:0]                  FL_DQ_IN,
    output logic [7:0]                       FL_DQ_OUT,
    output logic                             FL_DQ_OE
);
    import guard_cmd_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_PULSE, ST_HOLD, ST_DONE} state_t;
    state_t                 state_r;
    bus_cycle_t [3:0]       seq_r;
    logic [2:0]             seq_len_r;
    logic [2:0]             seq_idx_r;
    logic [CNT_W-1:0]       cnt_r;
    overlay_space_t         overlay_r;
    overlay_space_t         target_r;
    logic                   is_read_r;
    logic [7:0]             dq_s1_r;
    logic [7:0]             dq_s2_r;
    logic [7:0]             dq_s3_r;
    logic [7:0]             dq_filt_r;
    logic [7:0]             rsp_data_r;
    logic                   rsp_valid_r;
    logic                   timeout_r;
    bus_cycle_t [3:0]       seq_nxt;
    logic [2:0]             len_nxt;
    overlay_space_t         target_nxt;
    logic                   rd_nxt;

    // Command cycle: address bits from 11 up are don't care, driven low
    function automatic bus_cycle_t wr(input logic [10:0] a, input logic [7:0] d);
        wr = '{we: 1'b1, addr: {{(ADDR_W-CMD_ADDR_W){1'b0}}, a}, data: d};
    endfunction

    // Sector address keeps only the bits from 16 up
    function automatic bus_cycle_t wr_sec(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        wr_sec = '{we: 1'b1, addr: {a[ADDR_W-1:SECTOR_LSB], {SECTOR_LSB{1'b0}}},
                   data: d};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Sequence builder
    always_comb begin
        seq_nxt    = '{default: '0};
        len_nxt    = 3'd1;
        target_nxt = overlay_r;
        rd_nxt     = 1'b0;
        seq_nxt[0] = wr(UNLOCK1_ADDR, UNLOCK1_DATA);
        seq_nxt[1] = wr(UNLOCK2_ADDR, UNLOCK2_DATA);
        case (CMD.op)
            OP_ENTER_PERSIST: begin
                seq_nxt[2] = wr(UNLOCK1_ADDR, ENTER_PERSIST);
                len_nxt    = 3'd3;
                target_nxt = OV_PERSIST;
            end
            OP_ENTER_FREEZE: begin
                seq_nxt[2] = wr(UNLOCK1_ADDR, ENTER_FREEZE);
                len_nxt    = 3'd3;
                target_nxt = OV_FREEZE;
            end
            OP_ENTER_VOLAT: begin
                seq_nxt[2] = wr(UNLOCK1_ADDR, ENTER_VOLAT);
                len_nxt    = 3'd3;
                target_nxt = OV_VOLAT;
            end
            OP_ENTER_ECC: begin
                seq_nxt[2] = wr(UNLOCK1_ADDR, ENTER_ECC);
                len_nxt    = 3'd3;
                target_nxt = OV_ECC;
            end
            OP_PERSIST_PROG: begin
                seq_nxt[0] = wr('0, PROG_DATA);
                seq_nxt[1] = wr_sec(CMD.addr, SET_DATA);
                len_nxt    = 3'd2;
            end
            OP_PERSIST_ERASE: begin
                seq_nxt[0] = wr('0, ERASE_DATA);
                seq_nxt[1] = wr('0, ERASE_CONFIRM);
                len_nxt    = 3'd2;
            end
            OP_VOLAT_SET: begin
                seq_nxt[0] = wr('0, PROG_DATA);
                seq_nxt[1] = wr_sec(CMD.addr, SET_DATA);
                len_nxt    = 3'd2;
            end
            OP_VOLAT_CLEAR: begin
                seq_nxt[0] = wr('0, PROG_DATA);
                seq_nxt[1] = wr_sec(CMD.addr, CLEAR_DATA);
                len_nxt    = 3'd2;
            end
            OP_FREEZE_CLEAR: begin
                seq_nxt[0] = wr('0, PROG_DATA);
                seq_nxt[1] = wr('0, EXIT2_DATA);
                len_nxt    = 3'd2;
            end
            OP_READ: begin
                // Single read: array, guard status or ECC status by overlay
                seq_nxt[0] = '{we: 1'b0, addr: CMD.addr, data: 8'h00};
                rd_nxt     = 1'b1;
            end
            OP_EXIT: begin
                seq_nxt[0] = wr('0, EXIT1_DATA);
                seq_nxt[1] = wr('0, EXIT2_DATA);
                len_nxt    = 3'd2;
                target_nxt = OV_ARRAY;
                if (overlay_r == OV_ECC) begin
                    seq_nxt[0] = wr('0, RESET_DATA);
                    len_nxt    = 3'd1;
                end
            end
            default: begin // Never sends password, buffer or abort sequences
                seq_nxt[0] = wr('0, RESET_DATA);
                target_nxt = OV_ARRAY;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus cycle sequencer
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            state_r   <= ST_IDLE;
            seq_r     <= '{default: '0};
            seq_len_r <= 3'd0;
            seq_idx_r <= 3'd0;
            cnt_r     <= '0;
            target_r  <= OV_ARRAY;
            is_read_r <= 1'b0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (CMD_VALID) begin
                        seq_r     <= seq_nxt;
                        seq_len_r <= len_nxt;
                        target_r  <= target_nxt;
                        is_read_r <= rd_nxt;
                        seq_idx_r <= 3'd0;
                        cnt_r     <= CNT_W'(SETUP_CYC);
                        state_r   <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    cnt_r <= cnt_r - 1'b1;
                    if (cnt_r == 1) begin
                        cnt_r   <= seq_r[seq_idx_r].we ? CNT_W'(PULSE_CYC) : CNT_W'(READ_CYC);
                        state_r <= ST_PULSE;
                    end
                end
                ST_PULSE: begin
                    cnt_r <= cnt_r - 1'b1;
                    if (cnt_r == 1) begin
                        cnt_r   <= CNT_W'(SETUP_CYC);
                        state_r <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    cnt_r <= cnt_r - 1'b1;
                    if (cnt_r == 1) begin
                        if (seq_idx_r + 3'd1 == seq_len_r) begin
                            state_r <= ST_DONE;
                        end else begin
                            seq_idx_r <= seq_idx_r + 3'd1;
                            cnt_r     <= CNT_W'(SETUP_CYC);
                            state_r   <= ST_SETUP;
                        end
                    end
                end
                ST_DONE: state_r <= ST_IDLE;
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Overlay tracking, held until an enter, exit or reset sequence ends
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            overlay_r <= OV_ARRAY;
        end else if (state_r == ST_DONE) begin
            overlay_r <= target_r;
        end
    end

    // Read data synchroniser and capture
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            dq_s1_r     <= 8'h00;
            dq_s2_r     <= 8'h00;
            dq_s3_r     <= 8'h00;
            dq_filt_r   <= 8'h00;
            rsp_data_r  <= 8'h00;
            rsp_valid_r <= 1'b0;
            timeout_r   <= 1'b0;
        end else begin
            dq_s1_r     <= FL_DQ_IN;
            dq_s2_r     <= dq_s1_r;
            dq_s3_r     <= dq_s2_r;
            if (dq_s2_r == dq_s3_r) dq_filt_r <= dq_s3_r;
            rsp_valid_r <= (state_r == ST_DONE) && is_read_r;
            if (state_r == ST_PULSE && cnt_r == 1 && !seq_r[seq_idx_r].we) begin
                rsp_data_r <= dq_filt_r;
                // Timeout flag only meaningful outside array reads
                timeout_r  <= (overlay_r != OV_ARRAY) && dq_filt_r[TIMEOUT_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign CMD_READY    = (state_r == ST_IDLE);
    assign RSP_VALID    = rsp_valid_r;
    assign RSP_DATA     = rsp_data_r;
    // Bit 0 low means the sector or freeze bit is protected
    assign RSP_GUARDED  = (rsp_data_r[GUARD_BIT] == PROTECTED_VAL[GUARD_BIT]);
    assign OVERLAY      = overlay_r;
    assign TIMEOUT_SEEN = timeout_r;
    assign FL_ADDR      = (state_r == ST_IDLE) ? '0 : seq_r[seq_idx_r].addr;
    assign FL_CE_N      = !(state_r inside {ST_SETUP, ST_PULSE, ST_HOLD});
    assign FL_WE_N      = !(state_r == ST_PULSE && seq_r[seq_idx_r].we);
    assign FL_OE_N      = !(state_r == ST_PULSE && !seq_r[seq_idx_r].we);
    assign FL_DQ_OUT    = seq_r[seq_idx_r].data;
    assign FL_DQ_OE     = (state_r != ST_IDLE) && (state_r != ST_DONE) && seq_r[seq_idx_r].we;

    ////////////////////////////////////////////////////////////////////////
    a_exit_to_array: assert property (@(posedge CLK) disable iff (!NRST)
        state_r == ST_DONE && target_r == OV_ARRAY |=> overlay_r == OV_ARRAY)
        else $error("overlay not left after exit");
    a_overlay_holds: assert property (@(posedge CLK) disable iff (!NRST)
        state_r != ST_DONE |=> $stable(overlay_r))
        else $error("overlay changed without sequence end");
    a_sector_bits: assert property (@(posedge CLK) disable iff (!NRST)
        !FL_WE_N && FL_DQ_OUT[7:1] == '0 |-> FL_ADDR[SECTOR_LSB-1:0] == '0)
        else $error("low address bits driven on write");
    a_cmd_high_bits: assert property (@(posedge CLK) disable iff (!NRST)
        !FL_WE_N && FL_DQ_OUT != SET_DATA && FL_DQ_OUT != CLEAR_DATA
        |-> FL_ADDR[ADDR_W-1:CMD_ADDR_W] == '0)
        else $error("high address bits driven on command cycle");
    a_no_fight: assert property (@(posedge CLK) disable iff (!NRST)
        !FL_OE_N |-> !FL_DQ_OE && FL_WE_N)
        else $error("read while data driven");
    a_read_answer: assert property (@(posedge CLK) disable iff (!NRST)
        state_r == ST_DONE && is_read_r |=> RSP_VALID)
        else $error("read answer missing");
    a_guard_map: assert property (@(posedge CLK) disable iff (!NRST)
        RSP_VALID |-> RSP_GUARDED == !RSP_DATA[GUARD_BIT])
        else $error("guard status mapping wrong");
    a_ready_idle: assert property (@(posedge CLK) disable iff (!NRST)
        CMD_READY && CMD_VALID |=> !CMD_READY && !FL_CE_N)
        else $error("command not taken");
    c_enter_volat: cover property (@(posedge CLK) disable iff (!NRST)
        overlay_r == OV_VOLAT);
    c_enter_ecc: cover property (@(posedge CLK) disable iff (!NRST)
        overlay_r == OV_ECC);
    c_read_rsp: cover property (@(posedge CLK) disable iff (!NRST)
        RSP_VALID && overlay_r == OV_FREEZE);
endmodule

//--- verification/flash_guard_model.sv
// Behavioural flash device answering guard and overlay command sequences
`timescale 1ns/1ps
module flash_guard_model
    import guard_cmd_pkg::*;
#(
    parameter int ACC_NS = 60
)
(
    // Flash pins
    input  wire logic                             ce_n,
    input  wire logic                             we_n,
    input  wire logic                             oe_n,
    input  wire logic [guard_cmd_pkg::ADDR_W-1:0] addr,
    input  wire logic [7:0]                       wdata,
    input  wire logic                             wdata_oe,
    output logic [7:0]                            dq
);
    overlay_space_t ov = OV_ARRAY;
    logic [1:0]     step = 2'h0;
    logic [7:0]     pend = 8'h00;
    logic [2047:0]  pbit = '1;
    logic [2047:0]  vbit = '1;
    logic           frz = 1'b0;
    logic [7:0]     last_q = 8'ha5;
    logic [10:0]    sec;

    function automatic logic [7:0] rd_val(input logic [ADDR_W-1:0] a);
        case (ov)
            OV_PERSIST: rd_val = {7'h00, pbit[a[ADDR_W-1:SECTOR_LSB]]};
            OV_FREEZE:  rd_val = {7'h00, frz};
            OV_VOLAT:   rd_val = {7'h00, vbit[a[ADDR_W-1:SECTOR_LSB]]};
            OV_ECC:     rd_val = a[0] ? 8'h20 : 8'h00;
            default:    rd_val = a[7:0] ^ 8'h5a;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Write decoding, taken on the rising write strobe
    // Not modelled: password, lock register, suspend, buffer
    always @(posedge we_n) begin
        if (ce_n === 1'b0 && wdata_oe === 1'b1) begin
            sec = addr[ADDR_W-1:SECTOR_LSB];
            if (wdata == RESET_DATA) begin
                ov = OV_ARRAY;
                step = 2'h0;
                pend = 8'h00;
            end else if (ov != OV_ARRAY && pend == PROG_DATA) begin
                if (ov == OV_PERSIST && wdata == SET_DATA) pbit[sec] = 1'b0;
                if (ov == OV_VOLAT && wdata[7:1] == 7'h00) vbit[sec] = wdata[0];
                if (ov == OV_FREEZE && wdata == SET_DATA) frz = 1'b1;
                pend = 8'h00;
            end else if (ov == OV_PERSIST && pend == ERASE_DATA) begin
                if (wdata == ERASE_CONFIRM && addr == '0) pbit = '1;
                pend = 8'h00;
            end else if (ov != OV_ARRAY && pend == EXIT1_DATA) begin
                if (wdata == EXIT2_DATA) ov = OV_ARRAY;
                pend = 8'h00;
            end else if (step == 2'h2 && addr[10:0] == UNLOCK1_ADDR) begin
                case (wdata)
                    ENTER_PERSIST: ov = OV_PERSIST;
                    ENTER_FREEZE:  ov = OV_FREEZE;
                    ENTER_VOLAT:   ov = OV_VOLAT;
                    ENTER_ECC:     ov = OV_ECC;
                    default:       ov = ov;
                endcase
                step = 2'h0;
            end else if (step == 2'h1 && wdata == UNLOCK2_DATA && addr[10:0] == UNLOCK2_ADDR) begin
                step = 2'h2;
            end else if (wdata == UNLOCK1_DATA && addr[10:0] == UNLOCK1_ADDR) begin
                step = 2'h1;
            end else begin
                step = 2'h0;
                pend = wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read answer; released bus shows the inverse of the last value
    initial dq = 8'h5a;
    always begin
        @(negedge oe_n);
        dq = ~last_q;
        #(ACC_NS);
        if (!oe_n && !ce_n) last_q = rd_val(addr);
        dq = last_q;
        if (!oe_n) @(posedge oe_n);
        dq = ~last_q;
    end
endmodule

//--- verification/flash_sector_protect_cmd_decoder_tb_top.sv
// Self-checking bench for the guard command host against the flash model
`timescale 1ns/1ps
module flash_sector_protect_cmd_decoder_tb_top;
    import guard_cmd_pkg::*;

    localparam logic [ADDR_W-1:0] S1 = {11'h005, 16'h1234};
    localparam logic [ADDR_W-1:0] S2 = {11'h006, 16'h0000};
    logic              clk;
    logic              nrst;
    logic              cmd_valid;
    cmd_t              cmd;
    logic              cmd_ready;
    logic              rsp_valid;
    logic [7:0]        rsp_data;
    logic              rsp_guarded;
    overlay_space_t    overlay;
    logic              timeout_seen;
    logic [ADDR_W-1:0] fl_addr;
    logic              fl_ce_n;
    logic              fl_we_n;
    logic              fl_oe_n;
    logic [7:0]        fl_dq_in;
    logic [7:0]        fl_dq_out;
    logic              fl_dq_oe;
    logic              got_rsp;
    int                n_fail = 0;
    int                total_checks = 0;

    guard_cmd_host guard_cmd_host_i (.CLK(clk), .NRST(nrst), .CMD_VALID(cmd_valid), .CMD(cmd),
        .CMD_READY(cmd_ready), .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data),
        .RSP_GUARDED(rsp_guarded), .OVERLAY(overlay), .TIMEOUT_SEEN(timeout_seen),
        .FL_ADDR(fl_addr), .FL_CE_N(fl_ce_n), .FL_WE_N(fl_we_n), .FL_OE_N(fl_oe_n),
        .FL_DQ_IN(fl_dq_in), .FL_DQ_OUT(fl_dq_out), .FL_DQ_OE(fl_dq_oe));
    flash_guard_model #(.ACC_NS(60)) flash_guard_model_i (.ce_n(fl_ce_n), .we_n(fl_we_n),
        .oe_n(fl_oe_n), .addr(fl_addr), .wdata(fl_dq_out), .wdata_oe(fl_dq_oe), .dq(fl_dq_in));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // One command, held for one clock, then wait up to 2000 clocks for ready to return
    task automatic run(input op_t op, input logic [ADDR_W-1:0] a);
        int n;
        @(posedge clk);
        #1;
        cmd_valid = 1'b1;
        cmd.op = op;
        cmd.addr = a;
        @(posedge clk);
        #1;
        cmd_valid = 1'b0;
        for (n = 0; n < 2000 && cmd_ready !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        got_rsp = rsp_valid;
    endtask

    task automatic rd(input string what, input logic [ADDR_W-1:0] a, input logic [7:0] exp);
        run(OP_READ, a);
        check({what, " valid"}, {7'h00, got_rsp}, 8'h01);
        check(what, rsp_data, exp);
        check({what, " guarded"}, {7'h00, rsp_guarded}, {7'h00, exp[0] == 1'b0});
    endtask

    task automatic t_array();
        rd("array", 27'h0123456, 8'h56 ^ 8'h5a);
        check("overlay", 8'(overlay), 8'(OV_ARRAY));
        $display("test array done");
    endtask

    task automatic t_persist();
        run(OP_ENTER_PERSIST, '0);
        check("overlay", 8'(overlay), 8'(OV_PERSIST));
        rd("pers free", S1, 8'h01);
        run(OP_PERSIST_PROG, S1);
        rd("pers set", S1 | 27'h0000042, 8'h00);
        rd("pers other", S2, 8'h01);
        run(OP_PERSIST_ERASE, S2);
        rd("pers erased", S1, 8'h01);
        run(OP_EXIT, '0);
        check("overlay", 8'(overlay), 8'(OV_ARRAY));
        rd("array back", 27'h0000011, 8'h11 ^ 8'h5a);
        $display("test persistent done");
    endtask

    task automatic t_volat();
        run(OP_ENTER_VOLAT, '0);
        check("overlay", 8'(overlay), 8'(OV_VOLAT));
        run(OP_VOLAT_SET, S1);
        rd("vol set", S1 | 27'h000ffff, 8'h00);
        rd("vol other", S2, 8'h01);
        run(OP_VOLAT_CLEAR, S1);
        rd("vol clear", S1, 8'h01);
        run(OP_RESET, '0);
        check("overlay", 8'(overlay), 8'(OV_ARRAY));
        rd("array reset", 27'h00000a0, 8'ha0 ^ 8'h5a);
        $display("test volatile done");
    endtask

    task automatic t_freeze();
        run(OP_ENTER_FREEZE, '0);
        check("overlay", 8'(overlay), 8'(OV_FREEZE));
        rd("frz held", 27'h7654321, 8'h00);
        run(OP_FREEZE_CLEAR, S2);
        rd("frz clear", S1, 8'h01);
        run(OP_EXIT, '0);
        check("overlay", 8'(overlay), 8'(OV_ARRAY));
        $display("test freeze done");
    endtask

    task automatic t_ecc();
        run(OP_ENTER_ECC, '0);
        check("overlay", 8'(overlay), 8'(OV_ECC));
        rd("ecc odd", 27'h0000301, 8'h20);
        check("timeout", {7'h00, timeout_seen}, 8'h01);
        rd("ecc even", 27'h0000302, 8'h00);
        check("timeout", {7'h00, timeout_seen}, 8'h00);
        run(OP_EXIT, '0);
        check("overlay", 8'(overlay), 8'(OV_ARRAY));
        rd("array ecc", 27'h0000033, 8'h33 ^ 8'h5a);
        $display("test ecc done");
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        end_of_test();
    end

    initial begin
        nrst = 1'b0;
        cmd_valid = 1'b0;
        cmd = '0;
        got_rsp = 1'b0;
        repeat (20) @(posedge clk);
        #1;
        nrst = 1'b1;
        t_array();
        t_persist();
        t_volat();
        t_freeze();
        t_ecc();
        end_of_test();
    end
endmodule
